// >>> hw/mac_tx_consts.svh
// Purpose: Offsets, bit positions, reset values and counts of the transmit bid block
// Assumes: Page offsets are byte offsets into the register page
// Notes:   Definitions only
`ifndef MAC_TX_CONSTS_SVH
`define MAC_TX_CONSTS_SVH

// ----------------------------------------
// I/O port offsets
// ----------------------------------------
`define IO_DATA      4'h0
`define IO_CMD       4'h4
`define IO_LEN       4'h6
`define IO_EVQ       4'h8
`define IO_PTR       4'hA
`define IO_PDATA     4'hC

// ----------------------------------------
// Page offsets, event queue codes and reset value
// ----------------------------------------
`define PG_TRANSMIT_IRQ_CONFIG_REG     16'h0106
`define PG_BUFFER_IRQ_CONFIG_REG    16'h010A
`define PG_EVQ       16'h0120
`define PG_TXEV      16'h0128
`define PG_BUFEV     16'h012C
`define PG_BUS_STATUS     16'h0138
`define PG_CMD       16'h0144
`define PG_LEN       16'h0146
`define PG_WIN       16'h0A00
`define PG_WIN_SPAN  16'h05EE
`define PG_NONE      16'hFFFF
`define EVQ_TX_CODE  16'h0008
`define EVQ_BUF_CODE 16'h000C
`define REG_RST      16'h0000

// ----------------------------------------
// Bit positions
// ----------------------------------------
`define CMD_THR_LO   6
`define CMD_THR_HI   7
`define CMD_FORCE    8
`define CMD_CRC_SUP  12
`define CMD_PAD_DIS  13
`define BST_BID_ERR  7
`define BST_RDY_NOW  8
`define EV_OK        8
`define EV_LATE      9
`define EV_JABBER    10
`define EV_EXCESS    15
`define BEV_RDY      8
`define BEV_UNDER    9

// ----------------------------------------
// Lengths and counts
// ----------------------------------------
`define LEN_MIN      16'h0003
`define LEN_PAD      11'h03C
`define LEN_MAX_CRC  16'h05EA
`define LEN_MAX_RAW  16'h05EE
`define THR_0        12'h005
`define THR_1        12'h17D
`define THR_2        12'h3FD
`define LINK_GOOD_N  4

`endif

// >>> hw/mac_tx_pkg.sv
// Purpose: Types of the transmit bid block
// Assumes: Nothing
// Notes:   States are one-hot
`default_nettype none
package mac_tx_pkg;
    typedef enum logic [4:0] {
        H_IDLE  = 5'h01,
        H_BID   = 5'h02,
        H_WAIT  = 5'h04,
        H_READY = 5'h08,
        H_FILL  = 5'h10
    } host_state_e;
    typedef enum logic [2:0] {
        L_IDLE   = 3'h1,
        L_SEND   = 3'h2,
        L_RESULT = 3'h4
    } line_state_e;
    typedef logic [15:0] word_t;
endpackage
`default_nettype wire

// >>> hw/link_watch.sv
// Purpose: Link integrity check on received link pulses
// Assumes: Pulse inputs are one-cycle strobes in the clk domain
// Notes:   An invalid pulse restarts the count and drops link good
`include "mac_tx_consts.svh"
`default_nettype none
module link_watch #(
    parameter int GOOD_N = `LINK_GOOD_N
) (
    input  wire logic clk,
    input  wire logic sys_rst,
    input  wire logic pulse_valid,
    input  wire logic pulse_invalid,
    output logic      link_good
);
    logic [3:0] cnt_r;
    wire        reach = (cnt_r == 4'(GOOD_N - 1));

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cnt_r     <= 4'h0;
            link_good <= 1'b0;
        end else if (pulse_invalid) begin
            cnt_r     <= 4'h0;
            link_good <= 1'b0;
        end else if (pulse_valid && !link_good) begin
            cnt_r     <= reach ? 4'h0 : cnt_r + 4'h1;
            link_good <= reach;
        end
    end

    link_good_a: assert property (@(posedge clk) disable iff (sys_rst)
        $rose(link_good) |-> $past(pulse_valid) && !$past(pulse_invalid))
        else $error("link good without a valid pulse");
    link_drop_a: assert property (@(posedge clk) disable iff (sys_rst)
        pulse_invalid |=> !link_good && cnt_r == 4'h0)
        else $error("invalid pulse did not restart count");
endmodule
`default_nettype wire

// >>> hw/mac_tx_bid.sv
// Purpose: Transmit bid, buffer commit, frame fill and line hand-off
// Assumes: Bus strobes and lines come from pins; line side is on clk
// Notes:   One frame buffer; an unforced bid waits while a written frame occupies it and is ignored during fill
`include "mac_tx_consts.svh"
`default_nettype none
module mac_tx_bid
    import mac_tx_pkg::*;
#(
    parameter int MAX_WORDS = 759
) (
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic        ior_n,
    input  wire logic        iow_n,
    input  wire logic        memr_n,
    input  wire logic        memw_n,
    input  wire logic [15:0] sa,
    input  wire logic [15:0] sd_in,
    output logic      [15:0] sd_out,
    output logic             sd_oe,
    output logic             irq,
    output logic      [7:0]  line_data,
    output logic             line_valid,
    output logic             line_last,
    output logic             line_crc_append,
    input  wire logic        line_take,
    input  wire logic        line_ok,
    input  wire logic        line_excess,
    input  wire logic        line_jabber,
    input  wire logic        line_late,
    input  wire logic        nlp_tick,
    input  wire logic        auto_switch,
    input  wire logic        link_pulse_valid,
    input  wire logic        link_pulse_invalid,
    output logic             nlp_out,
    output logic             link_good
);
    import mac_tx_pkg::*;

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    logic [3:0] stb_s1_r, stb_s2_r, stb_d_r;
    word_t      a_s1_r, a_s2_r, d_s1_r, d_s2_r;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            stb_s1_r <= 4'h0;
            stb_s2_r <= 4'h0;
            stb_d_r  <= 4'h0;
        end else begin
            stb_s1_r <= ~{ior_n, iow_n, memr_n, memw_n};
            stb_s2_r <= stb_s1_r;
            stb_d_r  <= stb_s2_r;
        end
    end

    always_ff @(posedge clk) begin
        a_s1_r <= sa;
        a_s2_r <= a_s1_r;
        d_s1_r <= sd_in;
        d_s2_r <= d_s1_r;
    end

    // ----------------------------------------
    // Address decode
    // ----------------------------------------
    wire   rd_io  = stb_s2_r[3] & ~stb_d_r[3];
    wire   wr_io  = stb_s2_r[2] & ~stb_d_r[2];
    wire   rd_go  = rd_io | (stb_s2_r[1] & ~stb_d_r[1]);
    wire   wr_go  = wr_io | (stb_s2_r[0] & ~stb_d_r[0]);
    wire   io_ptr = (a_s2_r[3:0] == `IO_PTR);
    word_t ptr_r;
    wire word_t io_page = (a_s2_r[3:0] == `IO_DATA)  ? `PG_WIN :
                          (a_s2_r[3:0] == `IO_CMD)   ? `PG_CMD :
                          (a_s2_r[3:0] == `IO_LEN)   ? `PG_LEN :
                          (a_s2_r[3:0] == `IO_EVQ)   ? `PG_EVQ :
                          (a_s2_r[3:0] == `IO_PDATA) ? ptr_r   : `PG_NONE;
    wire word_t eff     = (rd_io | wr_io) ? io_page : a_s2_r;
    wire   hit_cmd   = (eff == `PG_CMD);
    wire   hit_len   = (eff == `PG_LEN);
    wire   hit_transmit_irq_config_reg = (eff == `PG_TRANSMIT_IRQ_CONFIG_REG);
    wire   hit_bufcf = (eff == `PG_BUFFER_IRQ_CONFIG_REG);
    wire   hit_txev  = (eff == `PG_TXEV);
    wire   hit_bufev = (eff == `PG_BUFEV);
    wire   hit_bus_status = (eff == `PG_BUS_STATUS);
    wire   hit_evq   = (eff == `PG_EVQ);
    wire   hit_win   = (eff >= `PG_WIN) && (eff < `PG_WIN + `PG_WIN_SPAN);

    // ----------------------------------------
    // Registers and flags
    // ----------------------------------------
    host_state_e hst_r, hst_nxt;
    line_state_e lst_r;
    word_t       cmd_r, transmit_irq_config_reg_r, buffer_irq_config_reg_r;
    logic [10:0] len_r, idx_r;
    logic [11:0] bytes_r;
    logic        live_r, bid_err_r, rdy_now_r;
    logic        ev_ok_r, ev_late_r, ev_jab_r, ev_exc_r, ev_rdy_r, ev_und_r;
    logic        underrun, line_done;
    word_t       mem [MAX_WORDS];

    wire word_t lw       = d_s2_r;
    wire   wr_cmd   = wr_go & hit_cmd;
    wire   force_wr = wr_cmd & lw[`CMD_FORCE];
    wire   wr_len   = wr_go & hit_len & (hst_r == H_BID);
    wire   len_bad  = (lw < `LEN_MIN) || (lw > `LEN_MAX_RAW) ||
                      ((lw > `LEN_MAX_CRC) && !cmd_r[`CMD_CRC_SUP]);
    wire   abort_ln = cmd_r[`CMD_FORCE] && (lw == 16'h0000);
    wire   space_ok = (lst_r == L_IDLE) && !live_r;
    wire   tx_pend  = ev_ok_r | ev_late_r | ev_jab_r | ev_exc_r;
    wire   buf_pend = ev_rdy_r | ev_und_r;
    wire   clr_buf  = rd_go & (hit_bufev | (hit_evq & buf_pend));
    wire   clr_tx   = rd_go & (hit_txev | (hit_evq & !buf_pend & tx_pend));
    wire   commit   = rd_go & (hst_r == H_READY) &
                      ((hit_bus_status & rdy_now_r) | ((hit_bufev | hit_evq) & ev_rdy_r));
    wire   win_wr   = wr_go & hit_win & (hst_r == H_FILL);
    wire   fill_end = win_wr && ({1'b0, len_r} <= bytes_r + 12'h002);
    wire   set_rdy  = (hst_r == H_WAIT) && space_ok && buffer_irq_config_reg_r[`BEV_RDY];

    // ----------------------------------------
    // Host side state machine
    // ----------------------------------------
    always_comb begin
        hst_nxt = hst_r;
        case (hst_r)
            H_BID: begin
                if (wr_len) begin
                    if (len_bad || abort_ln) begin
                        hst_nxt = H_IDLE;
                    end else begin
                        hst_nxt = space_ok ? H_READY : H_WAIT;
                    end
                end
            end
            H_WAIT:  hst_nxt = space_ok ? H_READY : H_WAIT;
            H_READY: hst_nxt = commit ? H_FILL : H_READY;
            H_FILL:  hst_nxt = fill_end ? H_IDLE : H_FILL;
            H_IDLE:  hst_nxt = H_IDLE;
            default: hst_nxt = H_IDLE;
        endcase
        if (force_wr || (wr_cmd && hst_r != H_FILL)) begin
            hst_nxt = H_BID;
        end
        if (lst_r == L_SEND && line_take && underrun) begin
            hst_nxt = H_IDLE;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            hst_r <= H_IDLE;
        end else begin
            hst_r <= hst_nxt;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cmd_r    <= `REG_RST;
            transmit_irq_config_reg_r  <= `REG_RST;
            buffer_irq_config_reg_r <= `REG_RST;
            ptr_r    <= `REG_RST;
            len_r    <= 11'h000;
        end else begin
            if (wr_cmd && (force_wr || hst_r != H_FILL)) cmd_r <= lw;
            if (wr_go && hit_transmit_irq_config_reg) transmit_irq_config_reg_r <= lw;
            if (wr_go && hit_bufcf) buffer_irq_config_reg_r <= lw;
            if (wr_io && io_ptr) ptr_r <= lw;
            if (wr_len && !len_bad) len_r <= lw[10:0];
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            bid_err_r <= 1'b0;
            rdy_now_r <= 1'b0;
        end else begin
            if (wr_len && len_bad && !abort_ln) bid_err_r <= 1'b1;
            else if (wr_cmd) bid_err_r <= 1'b0;
            if (wr_len && !len_bad && space_ok) rdy_now_r <= 1'b1;
            else if (hst_r == H_WAIT && space_ok && !buffer_irq_config_reg_r[`BEV_RDY]) rdy_now_r <= 1'b1;
            else if (commit || wr_cmd) rdy_now_r <= 1'b0;
        end
    end

    // ----------------------------------------
    // Frame buffer fill
    // ----------------------------------------
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            bytes_r <= 12'h000;
            live_r  <= 1'b0;
        end else if (force_wr || (lst_r != L_IDLE && line_done)) begin
            live_r  <= 1'b0;
        end else if (commit) begin
            bytes_r <= 12'h000;
            live_r  <= 1'b1;
        end else if (win_wr) begin
            bytes_r <= bytes_r + 12'h002;
        end
    end

    always_ff @(posedge clk) begin
        if (win_wr) mem[bytes_r[10:1]] <= lw;
    end

    // ----------------------------------------
    // Line side
    // ----------------------------------------
    logic [11:0] thr;
    always_comb begin
        case (cmd_r[`CMD_THR_HI:`CMD_THR_LO])
            2'b00:   thr = `THR_0;
            2'b01:   thr = `THR_1;
            2'b10:   thr = `THR_2;
            default: thr = {1'b0, len_r};
        endcase
    end

    wire        pad_on   = !cmd_r[`CMD_PAD_DIS] && (len_r < `LEN_PAD);
    wire [10:0] send_len = pad_on ? `LEN_PAD : len_r;
    wire        go       = (lst_r == L_IDLE) && live_r && !force_wr &&
                           (bytes_r >= thr || bytes_r >= {1'b0, len_r});
    wire [10:0] idx_n    = go ? 11'h000 : idx_r + 11'h001;
    assign underrun = (idx_n < len_r) && ({1'b0, idx_n} >= bytes_r) &&
                      (hst_r == H_FILL);
    wire        fail     = line_excess | line_jabber | line_late;
    assign line_done = fail | ((lst_r == L_RESULT) & line_ok) |
                       ((lst_r == L_SEND) & line_take & underrun);
    wire word_t mw       = mem[idx_n[10:1]];
    wire [7:0]  byte_n   = (idx_n >= len_r) ? 8'h00 : (idx_n[0] ? mw[15:8] : mw[7:0]);

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            lst_r      <= L_IDLE;
            idx_r      <= 11'h000;
            line_valid <= 1'b0;
            line_last  <= 1'b0;
            line_data  <= 8'h00;
        end else if (force_wr || (lst_r != L_IDLE && line_done)) begin
            lst_r      <= L_IDLE;
            line_valid <= 1'b0;
            line_last  <= 1'b0;
        end else if (go || (lst_r == L_SEND && line_take)) begin
            if (!go && line_last) begin
                lst_r      <= L_RESULT;
                line_valid <= 1'b0;
                line_last  <= 1'b0;
            end else begin
                lst_r      <= L_SEND;
                idx_r      <= idx_n;
                line_data  <= byte_n;
                line_valid <= 1'b1;
                line_last  <= (idx_n == send_len - 11'h001);
            end
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            line_crc_append <= 1'b0;
        end else if (go) begin
            line_crc_append <= !cmd_r[`CMD_CRC_SUP];
        end
    end

    // ----------------------------------------
    // Event flags, set wins over clear
    // ----------------------------------------
    wire in_tx = (lst_r != L_IDLE);
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            {ev_ok_r, ev_late_r, ev_jab_r, ev_exc_r, ev_rdy_r, ev_und_r} <= 6'h00;
        end else begin
            ev_ok_r   <= (lst_r == L_RESULT && line_ok && !fail) | (ev_ok_r & ~clr_tx);
            ev_late_r <= (in_tx & line_late) | (ev_late_r & ~clr_tx);
            ev_jab_r  <= (in_tx & line_jabber) | (ev_jab_r & ~clr_tx);
            ev_exc_r  <= (in_tx & line_excess) | (ev_exc_r & ~clr_tx);
            ev_rdy_r  <= set_rdy | (ev_rdy_r & ~clr_buf);
            ev_und_r  <= (lst_r == L_SEND && line_take && underrun) |
                         (ev_und_r & ~clr_buf);
        end
    end

    wire word_t txev_w  = word_t'({ev_exc_r, 4'h0, ev_jab_r, ev_late_r, ev_ok_r, 8'h00});
    wire word_t bufev_w = word_t'({ev_und_r, ev_rdy_r, 8'h00});
    wire word_t bus_status_w = word_t'({rdy_now_r, bid_err_r, 7'h00});
    wire word_t evq_w   = buf_pend ? (bufev_w | `EVQ_BUF_CODE) :
                          tx_pend  ? (txev_w | `EVQ_TX_CODE) : `REG_RST;
    wire word_t rd_mux  = (rd_io & io_ptr) ? ptr_r   :
                          hit_cmd   ? cmd_r   : hit_transmit_irq_config_reg ? transmit_irq_config_reg_r :
                          hit_bufcf ? buffer_irq_config_reg_r : hit_txev ? txev_w  :
                          hit_bufev ? bufev_w : hit_bus_status ? bus_status_w :
                          hit_evq   ? evq_w   : `REG_RST;
    wire irq_nxt = |(txev_w & transmit_irq_config_reg_r) | |(bufev_w & buffer_irq_config_reg_r);

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            sd_out  <= `REG_RST;
            irq     <= 1'b0;
            nlp_out <= 1'b0;
        end else begin
            if (rd_go) sd_out <= rd_mux;
            irq     <= irq_nxt;
            nlp_out <= nlp_tick & ~auto_switch;
        end
    end
    assign sd_oe = stb_s2_r[3] | stb_s2_r[1];

    link_watch #(.GOOD_N(`LINK_GOOD_N)) u_link (
        .clk           (clk),
        .sys_rst       (sys_rst),
        .pulse_valid   (link_pulse_valid),
        .pulse_invalid (link_pulse_invalid),
        .link_good     (link_good)
    );

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    sequence bid_ok_s;
        wr_len && !len_bad && !abort_ln && !force_wr;
    endsequence
    sequence send_end_s;
        lst_r == L_SEND && line_take && line_last && !fail && !force_wr;
    endsequence

    bid_error_a: assert property (wr_len && len_bad && !abort_ln && !force_wr
        |=> bid_err_r && hst_r == H_IDLE) else $error("bad length not flagged");
    short_reject_a: assert property (wr_len && lw < `LEN_MIN |=> !rdy_now_r)
        else $error("short frame accepted");
    ready_now_a: assert property (bid_ok_s ##0 space_ok
        |=> rdy_now_r && hst_r == H_READY) else $error("free space not reported");
    commit_gate_a: assert property ($rose(live_r)
        |-> $past(hst_r) == H_READY && hst_r == H_FILL) else $error("commit without ready read");
    fill_block_a: assert property (hst_r != H_FILL && !commit
        |=> $stable(bytes_r)) else $error("frame data taken outside fill");
    sent_ok_a: assert property (send_end_s ##1 (line_ok && !fail)
        |=> ev_ok_r && lst_r == L_IDLE) else $error("sent ok not flagged");
    fail_end_a: assert property (in_tx && line_jabber && !force_wr
        |=> lst_r == L_IDLE && ev_jab_r && !line_valid) else $error("failed frame not ended");
    force_clear_a: assert property (force_wr
        |=> !live_r && lst_r == L_IDLE && hst_r == H_BID) else $error("force kept frame");
    underrun_a: assert property (lst_r == L_SEND && line_take && underrun && !force_wr
        |=> ev_und_r && !line_valid) else $error("underrun not reported");
    pad_len_a: assert property (go && !cmd_r[`CMD_PAD_DIS] && len_r < `LEN_PAD
        |-> send_len == `LEN_PAD) else $error("short frame not padded");
    no_pulse_a: assert property (auto_switch |=> !nlp_out)
        else $error("link pulse sent in auto switch");
    irq_event_a: assert property (ev_ok_r && transmit_irq_config_reg_r[`EV_OK] |=> irq)
        else $error("enabled event raised no interrupt");
endmodule
`default_nettype wire

// >>> verif/line_sink.sv
// Purpose: Ethernet line stand-in that takes transmit bytes
// Assumes: Byte handshake on clk
// Notes:   Stalls every other cycle while slow is high
`default_nettype none
module line_sink (
    input  wire logic        clk,
    input  wire logic        clr,
    input  wire logic        slow,
    input  wire logic [7:0]  line_data,
    input  wire logic        line_valid,
    input  wire logic        line_last,
    input  wire logic        line_crc_append,
    output logic             line_take,
    output logic             line_ok,
    output logic      [15:0] cnt,
    output logic      [31:0] head,
    output logic             crc
);
    timeunit 1ns;
    timeprecision 100ps;
    logic ph;
    initial begin
        {line_take, line_ok, cnt, head, crc, ph} = '0;
    end
    // Success pulse follows the take of the final byte
    always @(posedge clk) begin
        line_ok <= line_take && line_valid && line_last;
        ph <= ~ph;
        if (clr) begin
            cnt <= '0;
        end else if (line_take && line_valid) begin
            if (cnt < 4) head[cnt[1:0]*8 +: 8] <= line_data;
            cnt <= cnt + 16'h0001;
            crc <= line_crc_append;
        end
        line_take <= line_valid && !(slow && ph) && !(line_take && line_last);
    end
endmodule
`default_nettype wire

// >>> verif/tb_mac_tx_bid.sv
// Purpose: Self-checking bench of the transmit bid block
// Assumes: I/O mode only; memory strobes stay idle
// Notes:   Each bus access holds its strobe six cycles
`default_nettype none
module tb_mac_tx_bid;
    timeunit 1ns;
    timeprecision 100ps;
    import mac_tx_pkg::*;
    typedef struct {word_t c; word_t l; word_t e;} row_s;
    logic clk, sys_rst, ior_n, iow_n, clr, slow, sd_oe, irq, crc;
    logic line_valid, line_last, line_crc_append, line_take, line_ok;
    logic nlp_tick, auto_switch, link_pulse_valid, link_pulse_invalid;
    logic nlp_out, link_good, jab;
    logic [7:0]  line_data;
    logic [15:0] sa, sd_in, sd_out, cnt;
    logic [31:0] head;
    word_t       rd;
    int          num_errors, n_compared;
    row_s rows [7] = '{'{16'h0000, 16'h0002, 16'h0080}, '{16'h3000, 16'h0002, 16'h0080},
        '{16'h0000, 16'h0003, 16'h0100}, '{16'h0000, 16'h05EB, 16'h0080},
        '{16'h1000, 16'h05EB, 16'h0100}, '{16'h1000, 16'h05EE, 16'h0100},
        '{16'h1000, 16'h05EF, 16'h0080}};
    mac_tx_bid u_mac_tx_bid (.clk, .sys_rst, .ior_n, .iow_n, .memr_n(1'b1), .memw_n(1'b1),
        .sa, .sd_in, .sd_out, .sd_oe, .irq, .line_data, .line_valid, .line_last,
        .line_crc_append, .line_take, .line_ok, .line_excess(1'b0), .line_jabber(jab),
        .line_late(1'b0), .nlp_tick, .auto_switch, .link_pulse_valid,
        .link_pulse_invalid, .nlp_out, .link_good);
    line_sink u_line_sink (.clk, .clr, .slow, .line_data, .line_valid, .line_last,
        .line_crc_append, .line_take, .line_ok, .cnt, .head, .crc);
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    task automatic stop_test;
        $display("compared %0d errors %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input word_t got, input word_t exp);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("Error %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic io(input logic wr, input logic [3:0] a, input word_t d);
        @(posedge clk);
        sa <= {12'h000, a};
        sd_in <= d;
        if (wr) iow_n <= 1'b0;
        else ior_n <= 1'b0;
        repeat (6) @(posedge clk);
        rd = sd_out;
        iow_n <= 1'b1;
        ior_n <= 1'b1;
        repeat (4) @(posedge clk);
    endtask
    task automatic st(input word_t e);
        io(1'b1, 4'hA, 16'h0138);
        io(1'b0, 4'hC, 16'h0000);
        chk(rd, e);
    endtask
    task automatic ev(input word_t e);
        io(1'b0, 4'h8, 16'h0000);
        chk(rd, e);
    endtask
    task automatic pg(input word_t a, input word_t d);
        io(1'b1, 4'hA, a);
        io(1'b1, 4'hC, d);
    endtask
    task automatic bid(input word_t c);
        io(1'b1, 4'h4, c);
        io(1'b1, 4'h6, 16'h0004);
    endtask
    task automatic fill;
        io(1'b1, 4'h0, 16'h2211);
        io(1'b1, 4'h0, 16'h4433);
    endtask
    task automatic frame(input word_t c, input logic s, input logic ec);
        slow <= s;
        clr <= 1'b1;
        bid(c);
        clr <= 1'b0;
        st(16'h0100);
        fill();
        for (int i = 0; i < 2000 && line_ok !== 1'b1; i++) @(negedge clk);
        chk(cnt, 16'h003C);
        chk(head[15:0], 16'h2211);
        chk(head[31:16], 16'h4433);
        chk({15'h0, crc}, {15'h0, ec});
        ev(16'h0108);
        ev(16'h0000);
        $display("frame %h done", c);
    endtask
    task automatic lp(input int n, input logic bad);
        repeat (n) begin
            @(posedge clk);
            link_pulse_valid <= ~bad;
            link_pulse_invalid <= bad;
            @(posedge clk);
            {link_pulse_valid, link_pulse_invalid} <= 2'b00;
        end
        repeat (3) @(posedge clk);
    endtask
    initial begin
        {sys_rst, ior_n, iow_n} = 3'b111;
        {sa, sd_in, clr, slow, nlp_tick, auto_switch, jab} = '0;
        {link_pulse_valid, link_pulse_invalid, num_errors, n_compared} = '0;
        repeat (12) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        chk({11'h0, irq, line_valid, sd_oe, nlp_out, link_good}, 16'h0000);
        $display("reset done");
        foreach (rows[i]) begin
            io(1'b1, 4'h4, rows[i].c);
            io(1'b1, 4'h6, rows[i].l);
            st(rows[i].e);
            io(1'b1, 4'h4, 16'h0100);
            io(1'b1, 4'h6, 16'h0000);
            st(16'h0000);
            $display("row %0d done", i);
        end
        frame(16'h00C0, 1'b0, 1'b1);
        frame(16'h10C0, 1'b1, 1'b0);
        // Interrupt mode: a second bid waits behind the frame on the line
        pg(16'h010A, 16'h0100);
        bid(16'h00C0);
        st(16'h0100);
        fill();
        bid(16'h00C0);
        st(16'h0000);
        for (int i = 0; i < 400 && irq !== 1'b1; i++) @(negedge clk);
        chk({15'h0, irq}, 16'h0001);
        ev(16'h010C);
        ev(16'h0108);
        fill();
        repeat (8) @(posedge clk);
        jab <= 1'b1;
        @(posedge clk);
        jab <= 1'b0;
        ev(16'h0408);
        ev(16'h0000);
        $display("interrupt done");
        // Line starts at five bytes and outruns the host
        slow <= 1'b0;
        pg(16'h010A, 16'h0000);
        io(1'b1, 4'h4, 16'h0000);
        io(1'b1, 4'h6, 16'h0040);
        st(16'h0100);
        repeat (3) io(1'b1, 4'h0, 16'h0000);
        ev(16'h020C);
        $display("underrun done");
        lp(3, 1'b0);
        lp(1, 1'b1);
        lp(3, 1'b0);
        chk({15'h0, link_good}, 16'h0000);
        lp(1, 1'b0);
        chk({15'h0, link_good}, 16'h0001);
        for (int a = 0; a < 2; a++) begin
            @(posedge clk);
            auto_switch <= a[0];
            nlp_tick <= 1'b1;
            @(posedge clk);
            nlp_tick <= 1'b0;
            @(negedge clk);
            chk({15'h0, nlp_out}, {15'h0, ~a[0]});
        end
        $display("link done");
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        chk({13'h0, irq, link_good, line_valid}, 16'h0000);
        st(16'h0000);
        $display("second reset done");
        stop_test();
    end
    initial begin
        #100us;
        num_errors++;
        stop_test();
    end
endmodule
`default_nettype wire
